/* File: verilog/mem_init_pkg.sv */
package mem_init_pkg;
  // Data-space register addresses
  localparam logic [9:0] ADDR_CFG_SH = 10'h0B9;
  localparam logic [9:0] ADDR_OSC_SH = 10'h0BA;
  localparam logic [9:0] ADDR_CFG_NV = 10'h0BB;
  localparam logic [9:0] ADDR_OSC_NV = 10'h0BC;
  localparam logic [9:0] ADDR_CMP_SH = 10'h0D0;
  localparam logic [9:0] ADDR_CMP_NV = 10'h0D1;
  localparam logic [9:0] ADDR_PIN_SH = 10'h0D3;
  localparam logic [9:0] ADDR_PIN_NV = 10'h0D4;
  localparam logic [9:0] ADDR_STATUS = 10'h0CF;
  localparam logic [9:0] ADDR_PORT_DATA = 10'h0B2;
  localparam logic [9:0] ADDR_PORT_DIR = 10'h0B3;
  localparam logic [9:0] SRAM_LO = 10'h000;
  localparam logic [9:0] SRAM_HI = 10'h03F;
  localparam logic [9:0] EE_LO = 10'h040;
  localparam logic [9:0] EE_HI = 10'h07F;
  localparam logic [9:0] EE_UPPER_LO = 10'h060;
  // Field positions
  localparam int CFG_TRIM_EN = 7;
  localparam int CFG_CLK_SRC = 6;
  localparam int CFG_WDOG = 4;
  localparam int CFG_BOR = 3;
  localparam int CFG_UPPER_LOCK = 2;
  localparam int CFG_WR_LOCK = 1;
  localparam int CFG_RD_LOCK = 0;
  localparam int PIN_DIR = 7;
  localparam int PIN_B_LEV = 6;
  localparam int PIN_A_LEV = 5;
  localparam int PORT_PIN_A = 0;
  localparam int PORT_PIN_B = 5;
  localparam int STATUS_READY = 7;
  localparam int PTR_SPACE = 10;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] OSC_RESET = 8'h80;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h10;
  // Data EEPROM write time
  localparam int EE_WRITE_US = 3000;
  localparam int CLK_MHZ = 40;
  localparam int EE_WRITE_CYC = EE_WRITE_US * CLK_MHZ;

  // Core access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic indexed;
    logic [10:0] ptr;
    logic [7:0] wdata;
  } core_req_t;

  // Access from programming interface
  typedef struct packed {
    logic rd;
    logic wr;
    logic code_space;
    logic [9:0] addr;
    logic [7:0] wdata;
  } prog_req_t;

  // Shadow configuration outputs
  typedef struct packed {
    logic trim_access_enable;
    logic clock_source_select;
    logic watchdog_reset_enable;
    logic brownout_enable;
    logic [2:0] brownout_calibration;
    logic [2:0] comparator_calibration;
    logic [4:0] current_source_calibration;
    logic [7:0] osc_trim;
  } shadow_cfg_t;
endpackage : mem_init_pkg

/* File: verilog/memory_access_init_shadow.sv */
`timescale 1ns/1ps
`default_nettype none
module memory_access_init_shadow #(
  parameter int EE_WRITE_CYCLES = mem_init_pkg::EE_WRITE_CYC
) (
  // Clock, reset and mode
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic prog_mode,
  // Core side access and answers
  input wire mem_init_pkg::core_req_t core_req,
  output logic [7:0] core_rdata,
  output logic core_fault,
  // Programmer side access and answers
  input wire mem_init_pkg::prog_req_t prog_req,
  output logic [7:0] prog_rdata,
  output logic prog_refused,
  // Code EEPROM array
  output logic [9:0] code_addr,
  input wire logic [7:0] code_rdata,
  output logic code_wr,
  output logic [7:0] code_wdata,
  // Data EEPROM write launch
  output logic [5:0] ee_addr,
  output logic ee_wr,
  output logic [7:0] ee_wdata,
  // SRAM and peripheral bus
  output logic [9:0] data_addr,
  output logic data_rd,
  output logic data_wr,
  output logic [7:0] data_wdata,
  input wire logic [7:0] data_rdata,
  // Port defaults and write status
  output logic [7:0] port_direction_reg,
  output logic [7:0] port_data_reg,
  output logic ee_ready,
  // Configuration from the shadows
  output mem_init_pkg::shadow_cfg_t shadow_cfg,
  output logic program_write_lock,
  output logic program_read_lock,
  output logic upper_eeprom_write_lock
);
  localparam int CW = $clog2(EE_WRITE_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_EE_BUSY = 3'b100
  } state_t;

  // Sequencer and write timer
  state_t state_ff, nxt_state;
  logic [CW-1:0] ee_cnt_ff;
  // Non-volatile images, four bytes packed; written in the generate loop below
  wire logic [31:0] nv_img;
  wire logic [7:0] cfg_nv = nv_img[7:0];
  wire logic [7:0] osc_nv = nv_img[15:8];
  wire logic [7:0] cmp_nv = nv_img[23:16];
  wire logic [7:0] pin_nv = nv_img[31:24];

  // Volatile shadows, reloaded on every reset
  logic [7:0] cfg_sh_ff;
  logic [7:0] osc_sh_ff;
  logic [7:0] cmp_sh_ff;
  logic [7:0] pin_sh_ff;
  // Port defaults and registered answers
  logic [7:0] port_dir_ff;
  logic [7:0] port_dat_ff;
  logic [7:0] core_rdata_ff;
  logic [7:0] prog_rdata_ff;

  // Core address formation
  // Plain indirect access sees only the low byte, so it can never reach code space;
  // only indexed access honours the space bit
  wire logic code_space = core_req.indexed & core_req.ptr[mem_init_pkg::PTR_SPACE];
  wire logic [9:0] eff_addr = core_req.indexed ? core_req.ptr[9:0]
                                               : {2'b00, core_req.ptr[7:0]};
  wire logic running = (state_ff != ST_LOAD);
  wire logic busy = (state_ff == ST_EE_BUSY);
  wire logic norm = running & ~prog_mode;

  // Region decode of the core address
  wire logic c_ee = ~code_space & (eff_addr >= mem_init_pkg::EE_LO) &
                    (eff_addr <= mem_init_pkg::EE_HI);
  wire logic c_upper = c_ee & (eff_addr >= mem_init_pkg::EE_UPPER_LO);
  wire logic c_osc = ~code_space & (eff_addr == mem_init_pkg::ADDR_OSC_SH);
  wire logic c_stat = ~code_space & (eff_addr == mem_init_pkg::ADDR_STATUS);
  wire logic c_pdat = ~code_space & (eff_addr == mem_init_pkg::ADDR_PORT_DATA);
  wire logic c_pdir = ~code_space & (eff_addr == mem_init_pkg::ADDR_PORT_DIR);
  // Init register hits; all of them are closed to the core in normal mode
  wire logic c_cfg_sh = (eff_addr == mem_init_pkg::ADDR_CFG_SH);
  wire logic c_cfg_nv = (eff_addr == mem_init_pkg::ADDR_CFG_NV);
  wire logic c_osc_nv = (eff_addr == mem_init_pkg::ADDR_OSC_NV);
  wire logic c_cmp_sh = (eff_addr == mem_init_pkg::ADDR_CMP_SH);
  wire logic c_cmp_nv = (eff_addr == mem_init_pkg::ADDR_CMP_NV);
  wire logic c_pin_sh = (eff_addr == mem_init_pkg::ADDR_PIN_SH);
  wire logic c_pin_nv = (eff_addr == mem_init_pkg::ADDR_PIN_NV);
  wire logic c_init = ~code_space & (c_cfg_sh | c_cfg_nv | c_osc_nv | c_cmp_sh | c_cmp_nv |
                                     c_pin_sh | c_pin_nv);
  wire logic trim_ok = cfg_sh_ff[mem_init_pkg::CFG_TRIM_EN];
  wire logic c_local = c_osc | c_stat | c_pdat | c_pdir | c_init;

  // Core refusal terms, kept apart so each traces to its rule
  // A refused access reaches no memory; the fault pulse tells the core
  wire logic c_any = core_req.rd | core_req.wr;
  wire logic c_bad_busy = busy;
  wire logic c_bad_init = c_init;
  wire logic c_bad_trim = c_osc & ~trim_ok;
  wire logic c_bad_ro = core_req.wr & (code_space | c_stat);
  wire logic c_bad_upper = core_req.wr & c_upper & upper_eeprom_write_lock;
  wire logic c_bad = norm & c_any & (c_bad_busy | c_bad_init | c_bad_trim | c_bad_ro |
                                     c_bad_upper);
  wire logic c_rd_ok = norm & core_req.rd & ~c_bad;
  wire logic c_wr_ok = norm & core_req.wr & ~c_bad;
  wire logic ee_launch_core = c_wr_ok & c_ee;

  // Programming access gating
  wire logic secured = program_write_lock | program_read_lock;
  wire logic p_on = running & prog_mode;
  wire logic p_code = prog_req.code_space;
  wire logic [9:0] pa = prog_req.addr;
  wire logic p_nv_cfg = ~p_code & (pa == mem_init_pkg::ADDR_CFG_NV);
  wire logic p_nv_osc = ~p_code & (pa == mem_init_pkg::ADDR_OSC_NV);
  wire logic p_nv_cmp = ~p_code & (pa == mem_init_pkg::ADDR_CMP_NV);
  wire logic p_nv_pin = ~p_code & (pa == mem_init_pkg::ADDR_PIN_NV);
  wire logic p_nv = p_nv_cfg | p_nv_osc | p_nv_cmp | p_nv_pin;
  wire logic p_ee = ~p_code & (pa >= mem_init_pkg::EE_LO) & (pa <= mem_init_pkg::EE_HI);
  wire logic p_upper = p_ee & (pa >= mem_init_pkg::EE_UPPER_LO);
  // Programmer refusal terms; a busy EEPROM refuses writes on this side too
  wire logic p_bad_wlock = program_write_lock;
  wire logic p_bad_sec = p_nv & secured;
  wire logic p_bad_busy = busy;
  wire logic p_bad_upper = p_upper & upper_eeprom_write_lock;
  wire logic p_wr_bad = p_bad_wlock | p_bad_sec | p_bad_busy | p_bad_upper;
  wire logic p_rd_bad = program_read_lock | p_bad_sec;
  wire logic p_wr_ok = p_on & prog_req.wr & ~p_wr_bad;
  wire logic p_rd_ok = p_on & prog_req.rd & ~p_rd_bad;
  wire logic ee_launch_prog = p_wr_ok & p_ee;
  wire logic ee_launch = ee_launch_core | ee_launch_prog;

  // Memory port steering
  assign code_addr = p_on ? pa : eff_addr;
  assign code_wr = p_wr_ok & p_code;
  assign code_wdata = prog_req.wdata;
  assign ee_addr = p_on ? pa[5:0] : eff_addr[5:0];
  assign ee_wr = ee_launch;
  assign ee_wdata = p_on ? prog_req.wdata : core_req.wdata;
  assign data_addr = p_on ? pa : eff_addr;
  // Bus strobes by path; the core path keeps local registers and EEPROM writes off the bus,
  // the programmer path keeps code space, the non-volatile images and EEPROM writes off it
  wire logic c_data_rd = c_rd_ok & ~code_space & ~c_local;
  wire logic p_data_rd = p_rd_ok & ~p_code & ~p_nv;
  wire logic c_data_wr = c_wr_ok & ~c_local & ~c_ee;
  wire logic p_data_wr = p_wr_ok & ~p_code & ~p_nv & ~p_ee;
  assign data_rd = c_data_rd | p_data_rd;
  assign data_wr = c_data_wr | p_data_wr;
  assign data_wdata = p_on ? prog_req.wdata : core_req.wdata;

  // Ready flag and status byte
  // Ready stays high through the load cycle, as no write can be pending then
  assign ee_ready = ~busy;
  wire logic [7:0] status_byte = {ee_ready, 7'h00};

  // Read multiplexer shared by both access paths
  // Unknown local addresses fall through to the bus data
  function automatic logic [7:0] local_read(input logic [9:0] a, input logic cs,
                                            input logic [7:0] ext, input logic [7:0] cd);
    logic [7:0] r;
    r = ext;
    if (cs) begin
      r = cd;
    end else begin
      case (a)
        mem_init_pkg::ADDR_CFG_SH: r = cfg_sh_ff;
        mem_init_pkg::ADDR_OSC_SH: r = osc_sh_ff;
        mem_init_pkg::ADDR_CFG_NV: r = cfg_nv;
        mem_init_pkg::ADDR_OSC_NV: r = osc_nv;
        mem_init_pkg::ADDR_CMP_SH: r = cmp_sh_ff;
        mem_init_pkg::ADDR_CMP_NV: r = cmp_nv;
        mem_init_pkg::ADDR_PIN_SH: r = pin_sh_ff;
        mem_init_pkg::ADDR_PIN_NV: r = pin_nv;
        mem_init_pkg::ADDR_STATUS: r = status_byte;
        mem_init_pkg::ADDR_PORT_DATA: r = port_dat_ff;
        mem_init_pkg::ADDR_PORT_DIR: r = port_dir_ff;
        default: r = ext;
      endcase
    end
    return r;
  endfunction : local_read

  wire logic [7:0] c_rd_val = local_read(eff_addr, code_space, data_rdata, code_rdata);
  wire logic [7:0] p_rd_val = local_read(pa, p_code, data_rdata, code_rdata);

  // Sequencer: one load cycle after reset, then run or EEPROM busy
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LOAD: nxt_state = ST_RUN;
      ST_RUN: if (ee_launch) nxt_state = ST_EE_BUSY;
      ST_EE_BUSY: if (ee_cnt_ff == CW'(1)) nxt_state = ST_RUN;
      default: nxt_state = ST_LOAD;
    endcase
  end

  // Write timer: loads on launch, counts down to zero
  // A reset during a write drops the timer; the cell contents are then undefined
  wire logic [CW-1:0] nxt_ee_cnt = ee_launch ? CW'(EE_WRITE_CYCLES) :
                                   (ee_cnt_ff != '0) ? ee_cnt_ff - CW'(1) : ee_cnt_ff;
  // State and timer registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_LOAD;
      ee_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ee_cnt_ff <= nxt_ee_cnt;
    end
  end

  // Non-volatile images, byte 0 upward: config, trim, comparator, pins.
  // No reset here: a reset reloads the shadows from them and must never clear them.
  // The power-up value stands in for the programmed cells.
  localparam logic [31:0] NV_FACTORY = {mem_init_pkg::PIN_RESET, mem_init_pkg::CMP_RESET,
                                        mem_init_pkg::OSC_RESET, mem_init_pkg::CFG_RESET};

  wire logic [3:0] nv_wsel = {p_nv_pin, p_nv_cmp, p_nv_osc, p_nv_cfg};
  wire logic nv_wr = p_wr_ok & ~rst;
  for (genvar i = 0; i < 4; i++) begin : g_nv
    logic [7:0] img_ff = NV_FACTORY[i*8 +: 8];
    // Only the programming path writes the cells
    always_ff @(posedge ref_clk) begin
      if (nv_wr & nv_wsel[i]) begin
        img_ff <= prog_req.wdata;
      end
    end
    assign nv_img[i*8 +: 8] = img_ff;
  end

  // Pin shadow loads on the first reset edge so the pins settle early
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_sh_ff <= pin_nv;
    end
  end

  // Reset images of the port registers; only pins 0 and 5 take defaults
  wire logic dflt_dir = pin_sh_ff[mem_init_pkg::PIN_DIR];
  wire logic dflt_a = pin_sh_ff[mem_init_pkg::PIN_A_LEV];
  wire logic dflt_b = pin_sh_ff[mem_init_pkg::PIN_B_LEV];
  wire logic [7:0] dir_load;
  wire logic [7:0] dat_load;
  for (genvar b = 0; b < 8; b++) begin : g_port_bit
    if (b == mem_init_pkg::PORT_PIN_A) begin : g_a
      assign dir_load[b] = dflt_dir;
      assign dat_load[b] = dflt_a;
    end else if (b == mem_init_pkg::PORT_PIN_B) begin : g_b
      assign dir_load[b] = dflt_dir;
      assign dat_load[b] = dflt_b;
    end else begin : g_other
      assign dir_load[b] = 1'b0;
      assign dat_load[b] = 1'b0;
    end
  end

  // Port direction: default image in the load cycle, then core writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_dir_ff <= '0;
    end else if (state_ff == ST_LOAD) begin
      port_dir_ff <= dir_load;
    end else if (c_wr_ok & c_pdir) begin
      port_dir_ff <= core_req.wdata;
    end
  end

  // Port data: default levels in the load cycle, then core writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      port_dat_ff <= '0;
    end else if (state_ff == ST_LOAD) begin
      port_dat_ff <= dat_load;
    end else if (c_wr_ok & c_pdat) begin
      port_dat_ff <= core_req.wdata;
    end
  end

  // Config shadow: reloaded in reset and the load cycle, closed to the core
  always_ff @(posedge ref_clk) begin
    if (rst | (state_ff == ST_LOAD)) begin
      cfg_sh_ff <= cfg_nv;
    end
  end

  // Trim shadow: stored value on reset, then the core may retune it
  always_ff @(posedge ref_clk) begin
    if (rst | (state_ff == ST_LOAD)) begin
      osc_sh_ff <= osc_nv;
    end else if (c_wr_ok & c_osc) begin
      osc_sh_ff <= core_req.wdata;
    end
  end

  // Comparator shadow: calibration applied at reset only
  always_ff @(posedge ref_clk) begin
    if (rst | (state_ff == ST_LOAD)) begin
      cmp_sh_ff <= cmp_nv;
    end
  end

  // Programmer refusal pulse, for either direction
  wire logic p_refuse = p_on & ((prog_req.wr & p_wr_bad) | (prog_req.rd & p_rd_bad));

  // Registered read data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_rdata_ff <= '0;
      prog_rdata_ff <= '0;
      core_fault <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      core_rdata_ff <= c_rd_ok ? c_rd_val : core_rdata_ff;
      prog_rdata_ff <= p_rd_ok ? p_rd_val : prog_rdata_ff;
      core_fault <= c_bad;
      prog_refused <= p_refuse;
    end
  end

  assign core_rdata = core_rdata_ff;
  assign prog_rdata = prog_rdata_ff;
  assign port_direction_reg = port_dir_ff;
  assign port_data_reg = port_dat_ff;

  // Configuration fanout from the shadows
  assign program_write_lock = cfg_sh_ff[mem_init_pkg::CFG_WR_LOCK];
  assign program_read_lock = cfg_sh_ff[mem_init_pkg::CFG_RD_LOCK];
  assign upper_eeprom_write_lock = cfg_sh_ff[mem_init_pkg::CFG_UPPER_LOCK];
  // Feature enables and calibration fields for the analog blocks
  assign shadow_cfg.trim_access_enable = trim_ok;
  assign shadow_cfg.clock_source_select = cfg_sh_ff[mem_init_pkg::CFG_CLK_SRC];
  assign shadow_cfg.watchdog_reset_enable = cfg_sh_ff[mem_init_pkg::CFG_WDOG];
  assign shadow_cfg.brownout_enable = cfg_sh_ff[mem_init_pkg::CFG_BOR];
  assign shadow_cfg.brownout_calibration = cmp_sh_ff[5:3];
  assign shadow_cfg.comparator_calibration = cmp_sh_ff[2:0];
  assign shadow_cfg.current_source_calibration = pin_sh_ff[4:0];
  assign shadow_cfg.osc_trim = osc_sh_ff;
endmodule : memory_access_init_shadow
`default_nettype wire

/* File: test/mem_access_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_access_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic prog_mode,
  input wire mem_init_pkg::core_req_t core_req,
  input wire logic [7:0] core_rdata,
  input wire logic core_fault,
  input wire logic [9:0] code_addr,
  input wire logic [7:0] code_rdata,
  input wire logic code_wr,
  input wire logic [5:0] ee_addr,
  input wire logic ee_wr,
  input wire logic ee_ready,
  input wire logic [9:0] data_addr,
  input wire logic data_wr,
  input wire logic program_write_lock,
  input wire logic upper_eeprom_write_lock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Indexed code read taken while no write is busy
  sequence code_rd_s;
    core_req.rd && core_req.indexed && core_req.ptr[10] && !prog_mode && ee_ready;
  endsequence
  // Core access arriving while a write is busy
  sequence busy_acc_s;
    !ee_ready && (core_req.rd || core_req.wr) && !prog_mode;
  endsequence
  AST_CODE_ADDR: assert property (code_rd_s |-> code_addr == core_req.ptr[9:0])
    else $error("code address differs from pointer");
  AST_CODE_DATA: assert property (code_rd_s |=> core_rdata == $past(code_rdata))
    else $error("code read data not returned");
  AST_CODE_RO: assert property (
    core_req.wr && core_req.indexed && core_req.ptr[10] && !prog_mode |=> core_fault)
    else $error("core code write not refused");
  AST_CODE_WR: assert property (code_wr |-> prog_mode && !program_write_lock)
    else $error("code write outside allowed mode");
  AST_EE_LAUNCH: assert property (ee_wr |=> !ee_ready)
    else $error("ready stays high after launch");
  AST_EE_DONE: assert property ($fell(ee_ready) |-> ##[1:16] ee_ready)
    else $error("ready never returns");
  AST_BUSY: assert property (busy_acc_s |-> !ee_wr && !data_wr ##1 core_fault)
    else $error("busy access not refused");
  AST_UPPER: assert property (ee_wr && upper_eeprom_write_lock |-> ee_addr < 6'h20)
    else $error("locked upper eeprom written");
  AST_PLAIN: assert property (
    data_wr && !prog_mode && !core_req.indexed |-> data_addr == {2'h0, core_req.ptr[7:0]})
    else $error("plain access used high pointer bits");
endmodule : mem_access_monitor
bind memory_access_init_shadow mem_access_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
  .prog_mode(prog_mode), .core_req(core_req), .core_rdata(core_rdata), .core_fault(core_fault),
  .code_addr(code_addr), .code_rdata(code_rdata), .code_wr(code_wr), .ee_addr(ee_addr),
  .ee_wr(ee_wr), .ee_ready(ee_ready), .data_addr(data_addr), .data_wr(data_wr),
  .program_write_lock(program_write_lock), .upper_eeprom_write_lock(upper_eeprom_write_lock));
`default_nettype wire

/* File: test/mem_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_far_model (
  input wire logic ref_clk,
  input wire logic [9:0] code_addr,
  output logic [7:0] code_rdata,
  input wire logic [9:0] data_addr,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata
);
  logic [7:0] ram [0:255];
  // Code store holds an address pattern, so a wrong address shows
  assign code_rdata = code_addr[7:0] ^ 8'hA5;
  // Unwritten bytes read unknown, no kinder than real cells
  assign data_rdata = ram[data_addr[7:0]];
  always_ff @(posedge ref_clk) begin
    if (data_wr) begin
      ram[data_addr[7:0]] <= data_wdata;
    end
  end
endmodule : mem_far_model
`default_nettype wire

/* File: test/memory_access_init_shadow_test.sv */
`timescale 1ns/1ps
`default_nettype none
module memory_access_init_shadow_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic prog_mode = 1'b0;
  mem_init_pkg::core_req_t core_req = '0;
  mem_init_pkg::prog_req_t prog_req = '0;
  mem_init_pkg::shadow_cfg_t shadow_cfg;
  logic [7:0] core_rdata, prog_rdata, code_rdata, code_wdata, ee_wdata, data_wdata, data_rdata;
  logic [7:0] port_direction_reg, port_data_reg, rd_q;
  logic [9:0] code_addr, data_addr;
  logic [5:0] ee_addr;
  logic core_fault, prog_refused, code_wr, ee_wr, data_rd, data_wr, ee_ready, flt_q, wr_q;
  logic program_write_lock, program_read_lock, upper_eeprom_write_lock;
  logic [13:0] ee_q;
  int n_errors = 0;
  int samples_checked = 0;
  // Short write time keeps the busy window visible
  memory_access_init_shadow #(.EE_WRITE_CYCLES(8)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .prog_mode(prog_mode), .core_req(core_req), .core_rdata(core_rdata),
    .core_fault(core_fault), .prog_req(prog_req), .prog_rdata(prog_rdata),
    .prog_refused(prog_refused), .code_addr(code_addr), .code_rdata(code_rdata),
    .code_wr(code_wr), .code_wdata(code_wdata), .ee_addr(ee_addr), .ee_wr(ee_wr),
    .ee_wdata(ee_wdata), .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .port_direction_reg(port_direction_reg),
    .port_data_reg(port_data_reg), .ee_ready(ee_ready), .shadow_cfg(shadow_cfg),
    .program_write_lock(program_write_lock), .program_read_lock(program_read_lock),
    .upper_eeprom_write_lock(upper_eeprom_write_lock));
  mem_far_model u_far (.ref_clk(ref_clk), .code_addr(code_addr), .code_rdata(code_rdata),
    .data_addr(data_addr), .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));
  // Clock at 25 ns period
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Reset, then let the load cycle pass
  task automatic do_reset;
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : do_reset
  // One-cycle request; strobes seen mid-cycle, answers one cycle on
  task automatic op(input logic pg, input logic r, input logic w, input logic x,
                    input logic [10:0] p, input logic [7:0] d);
    @(negedge ref_clk);
    if (pg) prog_req = '{r, w, x, p[9:0], d};
    else core_req = '{r, w, x, p, d};
    #1 wr_q = ee_wr | code_wr | data_wr;
    ee_q = {ee_addr, ee_wdata};
    @(negedge ref_clk);
    core_req = '0;
    prog_req = '0;
    flt_q = pg ? prog_refused : core_fault;
    rd_q = pg ? prog_rdata : core_rdata;
  endtask : op
  task automatic t_defaults;
    chk(shadow_cfg.osc_trim, 8'h80);
    chk(shadow_cfg.current_source_calibration, 8'h10);
    chk({port_direction_reg[5], port_direction_reg[0]}, 8'h00);
    chk({port_data_reg[5], port_data_reg[0]}, 8'h00);
    chk({program_write_lock, program_read_lock, upper_eeprom_write_lock}, 8'h00);
    chk(ee_ready, 8'h01);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_access;
    op(0, 0, 1, 1, 11'h555, 8'h00);
    chk({flt_q, wr_q}, 8'h02);
    op(0, 0, 1, 0, 11'h010, 8'h3C);
    chk(flt_q, 8'h00);
    op(0, 1, 0, 0, 11'h410, 8'h00);
    chk(rd_q, 8'h3C);
    op(0, 1, 0, 1, 11'h010, 8'h00);
    chk(rd_q, 8'h3C);
    op(0, 1, 0, 1, 11'h555, 8'h00);
    chk(rd_q, 8'hF0);
    op(0, 1, 0, 0, 11'h0BA, 8'h00);
    chk(flt_q, 8'h01);
    op(0, 1, 0, 0, 11'h0BB, 8'h00);
    chk(flt_q, 8'h01);
    $display("access done");
  endtask : t_access
  task automatic t_eeprom;
    int n;
    op(0, 0, 1, 0, 11'h045, 8'h77);
    chk({wr_q, ee_ready}, 8'h02);
    chk(ee_q[13:8], 8'h05);
    chk(ee_q[7:0], 8'h77);
    op(0, 1, 0, 0, 11'h010, 8'h00);
    chk(flt_q, 8'h01);
    n = 0;
    while (ee_ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(ee_ready, 8'h01);
    $display("eeprom done");
  endtask : t_eeprom
  task automatic t_program;
    prog_mode = 1'b1;
    op(1, 0, 1, 1, 11'h123, 8'h9C);
    chk({wr_q, flt_q}, 8'h02);
    op(1, 0, 1, 0, 11'h0D4, 8'hE3);
    op(1, 0, 1, 0, 11'h0D1, 8'h2B);
    op(1, 0, 1, 0, 11'h0BB, 8'hDE);
    chk(flt_q, 8'h00);
    op(1, 1, 0, 0, 11'h010, 8'h00);
    chk(rd_q, 8'h3C);
    prog_mode = 1'b0;
    do_reset();
    chk(shadow_cfg[22:19], 8'h0F);
    chk({upper_eeprom_write_lock, program_write_lock, program_read_lock}, 8'h06);
    chk({shadow_cfg.brownout_calibration, shadow_cfg.comparator_calibration}, 8'h2B);
    chk(shadow_cfg.current_source_calibration, 8'h03);
    chk({port_direction_reg[5], port_direction_reg[0]}, 8'h03);
    chk({port_data_reg[5], port_data_reg[0]}, 8'h03);
    op(0, 1, 0, 0, 11'h0BA, 8'h00);
    chk(flt_q, 8'h00);
    op(0, 0, 1, 0, 11'h070, 8'h11);
    chk({flt_q, wr_q}, 8'h02);
    prog_mode = 1'b1;
    op(1, 0, 1, 1, 11'h123, 8'h00);
    chk({flt_q, wr_q}, 8'h02);
    op(1, 1, 0, 0, 11'h0BB, 8'h00);
    chk(flt_q, 8'h01);
    prog_mode = 1'b0;
    $display("program done");
  endtask : t_program
  // Main sequence
  initial begin
    do_reset();
    t_defaults();
    t_access();
    t_eeprom();
    t_program();
    finish_test();
  end
  // Whole run needs under two hundred cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end
endmodule : memory_access_init_shadow_test
`default_nettype wire
